// file: logic/adc_seq_pkg.sv
// constants for the converter sequencer: register map, fields, resets
// assumes a byte-wide register view placed in the low bits of 32-bit words
//
// Summary of operation
// - control write starts a new sequence
// - write mid-sequence aborts and clears flags
// - length bit: 0 four, 1 eight conversions
// - repeat bit: 0 one sequence, 1 continuous
// - single mode converts one selected input
// - group mode: conversion n to result n
// - group mode ignores low select bits
// - select codes: inputs, reserved, references, test
// - done flag set after first sequence
// - done flag clear: control write, or result 0 access in fast clear mode
// - 3-bit counter shows next result index
// - per-result flag set, held until read
// - fast clear needs no status read first
// - flags writable only in special mode
// - test registers read zero outside special mode
// - approximation bits readable and loadable
// - module reset bit restores reset, keeps power
// - factory test select and output mux bit
// - status byte layout: flag, four zero bits, counter
// - fast clear on any result access
// - sequence complete raises interrupt when enabled
// - power bit low aborts sequence
package adc_seq_pkg;
    // register indices (word offsets); byte address is index times four
    localparam logic [7:0] IDX_STATUS_HI = 8'h66;
    localparam logic [7:0] IDX_DONE_FLAGS = 8'h67;
    localparam logic [7:0] IDX_TEST_HI = 8'h68;
    localparam logic [7:0] IDX_TEST_LO = 8'h69;
    localparam logic [7:0] IDX_SEQ_CTRL = 8'h65;
    localparam logic [7:0] IDX_MODE_CTRL = 8'h62;
    localparam logic [7:0] IDX_RESULT_BASE = 8'h70;
    // sequence control fields
    localparam int CTRL_LEN_BIT = 6;
    localparam int CTRL_REPEAT_BIT = 5;
    localparam int CTRL_GROUP_BIT = 4;
    // mode control fields
    localparam int MODE_PWR_BIT = 7;
    localparam int MODE_FFC_BIT = 6;
    localparam int MODE_IRQ_EN_BIT = 1;
    localparam int MODE_IRQ_FLAG_BIT = 0;
    // test low byte fields
    localparam int TST_RST_BIT = 5;
    localparam int TST_OUT_BIT = 4;
    // status layout
    localparam int STAT_DONE_BIT = 7;
    // reset values
    localparam logic [7:0] SEQ_CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [9:0] APPROX_RESET = 10'h000;
    // timing: cycles per conversion (stand-in for the analog sequencer)
    localparam int CONV_TIME_NS = 500;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // channel codes
    localparam logic [3:0] CH_HIGH_REF = 4'hc;
    localparam logic [3:0] CH_LOW_REF = 4'hd;
    localparam logic [3:0] CH_MID_REF = 4'he;
    localparam logic [3:0] CH_TEST = 4'hf;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_RUN = 1'b1
    } seq_state_t;
endpackage

// file: logic/adc_sequence_control.sv
// converter sequencer: control, status, result and test registers
// assumes an Avalon-MM master and an analog core that returns a 10-bit
// result on conv_result_in at the end of each CONV_CYCLES_P-cycle conversion
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module adc_sequence_control
    import adc_seq_pkg::*;
#(
    parameter int CONV_CYCLES_P = CONV_CYCLES
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic special_mode_in,
    input wire logic [9:0] conv_result_in,
    output logic [3:0] conv_channel_out,
    output logic conv_active_out,
    output logic [3:0] factory_test_sel_out,
    output logic test_mux_out,
    output logic seq_irq_out
);
    seq_state_t state_reg;
    logic [7:0] seq_ctrl_reg;
    logic [7:0] mode_ctrl_reg;
    logic seq_done_flag_reg;
    logic first_done_reg;
    logic [2:0] conv_position_reg;
    logic [7:0] result_done_flags_reg;
    logic [7:0] status_seen_reg;
    logic [9:0] approx_bits_reg;
    logic [5:0] test_lo_reg;
    logic [15:0] timer_reg;
    logic [9:0] result_mem [8];
    logic ack_reg;
    logic [31:0] rdata_reg;

    // one-cycle wait state: a request is answered the cycle after it rises
    logic req;
    logic rd_hit;
    logic wr_hit;
    logic [7:0] wbyte;
    logic [7:0] idx;
    assign req = (avs_read_in | avs_write_in) & ~ack_reg;
    assign avs_waitrequest_out = req;
    assign rd_hit = avs_read_in & ack_reg;
    assign wr_hit = avs_write_in & ack_reg & avs_byteenable_in[0];
    assign wbyte = avs_writedata_in[7:0];
    assign idx = avs_address_in;

    // index of a result register, or 4'h8 when not a result address
    function automatic logic [3:0] result_index(input logic [7:0] a);
        if (a >= IDX_RESULT_BASE && a < IDX_RESULT_BASE + 8'h08) begin
            result_index = {1'b0, a[2:0]};
        end else begin
            result_index = 4'h8;
        end
    endfunction

    logic seq_wr;
    logic module_rst;
    logic pwr_off;
    logic conv_end;
    logic [3:0] rd_res;
    logic seq_len_last;
    assign seq_wr = wr_hit && idx == IDX_SEQ_CTRL;
    assign module_rst = test_lo_reg[TST_RST_BIT];
    assign pwr_off = ~mode_ctrl_reg[MODE_PWR_BIT];
    assign conv_end = state_reg == SEQ_RUN
        && timer_reg == 16'(CONV_CYCLES_P - 1);
    assign rd_res = (ack_reg && (avs_read_in || avs_write_in))
        ? result_index(idx) : 4'h8;
    assign seq_len_last = seq_ctrl_reg[CTRL_LEN_BIT]
        ? (conv_position_reg == 3'h7) : (conv_position_reg == 3'h3);

    // bus handshake: ack toggles so every request waits exactly one cycle
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // channel in use; group mode replaces low select bits by the counter
    logic [3:0] chan;
    always_comb begin
        if (seq_ctrl_reg[CTRL_GROUP_BIT]) begin
            if (seq_ctrl_reg[CTRL_LEN_BIT]) begin
                chan = {seq_ctrl_reg[3], conv_position_reg};
            end else begin
                chan = {seq_ctrl_reg[3:2], conv_position_reg[1:0]};
            end
        end else begin
            chan = seq_ctrl_reg[3:0];
        end
    end

    // sequencer: start on control write, abort on power-off or reset bit
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= SEQ_IDLE;
            timer_reg <= 16'h0000;
            conv_position_reg <= 3'h0;
        end else if (module_rst || pwr_off) begin
            state_reg <= SEQ_IDLE;
            timer_reg <= 16'h0000;
            conv_position_reg <= 3'h0;
        end else if (seq_wr) begin
            state_reg <= SEQ_RUN;
            timer_reg <= 16'h0000;
            conv_position_reg <= 3'h0;
        end else begin
            case (state_reg)
                SEQ_IDLE: begin
                    timer_reg <= 16'h0000;
                end
                SEQ_RUN: begin
                    if (conv_end) begin
                        timer_reg <= 16'h0000;
                        if (seq_len_last) begin
                            conv_position_reg <= 3'h0;
                            if (!seq_ctrl_reg[CTRL_REPEAT_BIT]) begin
                                state_reg <= SEQ_IDLE;
                            end
                        end else begin
                            conv_position_reg <= conv_position_reg + 3'h1;
                        end
                    end else begin
                        timer_reg <= timer_reg + 16'h0001;
                    end
                end
                default: state_reg <= SEQ_IDLE;
            endcase
        end
    end

    // result store follows the counter in both modes
    always_ff @(posedge clk_in) begin
        if (conv_end) begin
            result_mem[conv_position_reg] <= conv_result_in;
        end
    end

    // control registers; power bit survives the module reset bit
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seq_ctrl_reg <= SEQ_CTRL_RESET;
            mode_ctrl_reg <= MODE_CTRL_RESET;
        end else if (module_rst) begin
            seq_ctrl_reg <= SEQ_CTRL_RESET;
            mode_ctrl_reg <= MODE_CTRL_RESET
                | (mode_ctrl_reg & (8'h01 << MODE_PWR_BIT));
        end else begin
            if (seq_wr) begin
                seq_ctrl_reg <= wbyte;
            end
            if (wr_hit && idx == IDX_MODE_CTRL) begin
                mode_ctrl_reg[7:1] <= wbyte[7:1];
            end
            // irq flag is read-only; set on completion, cleared by new start
            if (conv_end && seq_len_last
                && mode_ctrl_reg[MODE_IRQ_EN_BIT]) begin
                mode_ctrl_reg[MODE_IRQ_FLAG_BIT] <= 1'b1;
            end else if (seq_wr) begin
                mode_ctrl_reg[MODE_IRQ_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // sequence-done flag; control write and reset bit beat set, set beats the other clears
    logic seq_finish;
    assign seq_finish = conv_end && seq_len_last && !first_done_reg;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seq_done_flag_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end else if (module_rst) begin
            seq_done_flag_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end else if (seq_wr) begin
            seq_done_flag_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end else if (seq_finish) begin
            seq_done_flag_reg <= 1'b1;
            first_done_reg <= 1'b1;
        end else if (special_mode_in && wr_hit && idx == IDX_STATUS_HI) begin
            seq_done_flag_reg <= wbyte[STAT_DONE_BIT];
        end else if (mode_ctrl_reg[MODE_FFC_BIT] && rd_res == 4'h0) begin
            seq_done_flag_reg <= 1'b0;
        end
    end

    // per-result flags; status read arms the normal-mode clear
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_flag
            logic set_now;
            logic clr_now;
            assign set_now = conv_end && conv_position_reg == 3'(g);
            assign clr_now = rd_res == 4'(g) && result_done_flags_reg[g]
                && (mode_ctrl_reg[MODE_FFC_BIT] || status_seen_reg[g]);
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    result_done_flags_reg[g] <= 1'b0;
                    status_seen_reg[g] <= 1'b0;
                end else if (module_rst || seq_wr) begin
                    result_done_flags_reg[g] <= 1'b0;
                    status_seen_reg[g] <= 1'b0;
                end else if (set_now) begin
                    result_done_flags_reg[g] <= 1'b1;
                    status_seen_reg[g] <= 1'b0;
                end else if (special_mode_in && wr_hit
                    && idx == IDX_DONE_FLAGS) begin
                    result_done_flags_reg[g] <= wbyte[g];
                end else if (clr_now) begin
                    result_done_flags_reg[g] <= 1'b0;
                    status_seen_reg[g] <= 1'b0;
                end else if (rd_hit && (idx == IDX_DONE_FLAGS
                    || idx == IDX_STATUS_HI)) begin
                    status_seen_reg[g] <= result_done_flags_reg[g];
                end
            end
        end
    endgenerate

    // test registers: only special mode may write them; each conversion end loads approx_bits_reg
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            approx_bits_reg <= APPROX_RESET;
            test_lo_reg <= 6'h00;
        end else if (module_rst) begin
            approx_bits_reg <= APPROX_RESET;
            test_lo_reg <= 6'h00;
        end else begin
            if (conv_end) begin
                approx_bits_reg <= conv_result_in;
            end else if (special_mode_in && wr_hit
                && idx == IDX_TEST_HI) begin
                approx_bits_reg[9:2] <= wbyte;
            end else if (special_mode_in && wr_hit
                && idx == IDX_TEST_LO) begin
                approx_bits_reg[1:0] <= wbyte[7:6];
            end
            if (special_mode_in && wr_hit && idx == IDX_TEST_LO) begin
                test_lo_reg <= wbyte[5:0];
            end
        end
    end

    // read mux; unmapped indices and guarded test bytes read as zero
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        if (idx == IDX_STATUS_HI) begin
            rbyte = {seq_done_flag_reg, 4'h0, conv_position_reg};
        end else if (idx == IDX_DONE_FLAGS) begin
            rbyte = result_done_flags_reg;
        end else if (idx == IDX_TEST_HI && special_mode_in) begin
            rbyte = approx_bits_reg[9:2];
        end else if (idx == IDX_TEST_LO && special_mode_in) begin
            rbyte = {approx_bits_reg[1:0], test_lo_reg};
        end else if (idx == IDX_SEQ_CTRL) begin
            rbyte = seq_ctrl_reg;
        end else if (idx == IDX_MODE_CTRL) begin
            rbyte = mode_ctrl_reg;
        end else if (result_index(idx) != 4'h8) begin
            rbyte = result_mem[idx[2:0]][9:2];
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read_in && !ack_reg) begin
            rdata_reg <= {24'h00_0000, rbyte};
        end
    end
    assign avs_readdata_out = rdata_reg;

    // outward signals
    assign conv_channel_out = chan;
    assign conv_active_out = state_reg == SEQ_RUN;
    assign factory_test_sel_out = test_lo_reg[3:0];
    assign test_mux_out = test_lo_reg[TST_OUT_BIT];
    assign seq_irq_out = mode_ctrl_reg[MODE_IRQ_FLAG_BIT];

    a_seq_start: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        seq_wr && !module_rst && mode_ctrl_reg[MODE_PWR_BIT]
        |=> conv_active_out && conv_position_reg == 3'h0)
        else $error("control write did not start a sequence");
    a_abort_flags: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        seq_wr |=> result_done_flags_reg == 8'h00)
        else $error("flags not cleared on restart");
    a_len_four: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !seq_ctrl_reg[CTRL_LEN_BIT] |-> conv_position_reg < 3'h4)
        else $error("four-length sequence overran");
    a_single_halt: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        conv_end && seq_len_last && !seq_ctrl_reg[CTRL_REPEAT_BIT]
        && !seq_wr && !pwr_off && !module_rst |=> !conv_active_out)
        else $error("single sequence did not halt");
    a_single_chan: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !seq_ctrl_reg[CTRL_GROUP_BIT]
        |-> conv_channel_out == seq_ctrl_reg[3:0])
        else $error("single mode channel wrong");
    a_done_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        seq_finish && !seq_wr && !module_rst |=> seq_done_flag_reg)
        else $error("sequence-done flag not set");
    a_flag_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        conv_end && !seq_wr && !module_rst
        |=> result_done_flags_reg[$past(conv_position_reg)])
        else $error("result flag not set");
    a_test_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ack_reg && avs_read_in && !special_mode_in
        && (idx == IDX_TEST_HI || idx == IDX_TEST_LO)
        |-> avs_readdata_out == 32'h0000_0000)
        else $error("test register readable outside special mode");
endmodule

// file: sim/adc_sequence_control_tb_top.sv
// bench for the converter sequencer: register, sequence and test checks
// assumes adc_seq_pkg and adc_sequence_control are compiled first
`timescale 1ns/1ps
module adc_sequence_control_tb_top;
    import adc_seq_pkg::*;
    // longer than two bus accesses, so status reads land inside one conversion
    localparam int CONV_P = 8;
    logic clk_in;
    logic arst_n_in;
    logic [7:0] address;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic waitreq;
    logic special;
    logic [9:0] result;
    logic [3:0] channel;
    logic active;
    logic [3:0] test_sel;
    logic test_mux;
    logic irq;
    logic [7:0] q;
    logic [3:0] c;
    logic [3:0] codes [5] = '{4'h5, 4'hc, 4'hd, 4'he, 4'hf};
    int error_cnt;
    int cmp_count;

    adc_sequence_control #(.CONV_CYCLES_P(CONV_P)) i_dut (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .avs_address_in(address),
        .avs_read_in(rd),
        .avs_write_in(wr),
        .avs_writedata_in(wdata),
        .avs_byteenable_in(4'h1),
        .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq),
        .special_mode_in(special),
        .conv_result_in(result),
        .conv_channel_out(channel),
        .conv_active_out(active),
        .factory_test_sel_out(test_sel),
        .test_mux_out(test_mux),
        .seq_irq_out(irq)
    );

    // 40 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // analog stand-in: result carries the channel, so placement shows
    always @(posedge clk_in) begin
        result <= {channel, 6'h15};
    end

    task automatic finish_test();
        $display("error_cnt %0d cmp_count %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one bus access; held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        address <= a;
        wr <= w;
        rd <= ~w;
        wdata <= {24'h000000, d};
        @(posedge clk_in);
        while (waitreq !== 1'b0 && n < 50) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 50) begin
            error_cnt++;
            $display("[FAIL] waitrequest expected 0 seen %b", waitreq);
            finish_test();
        end
        // read data taken at the same edge that ends the wait
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rchk(input string name, input logic [7:0] a,
                        input logic [7:0] mask, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(name, exp, q & mask);
    endtask

    // bounded wait for end of activity or for the interrupt line
    task automatic wait_for(input bit want_irq);
        int n;
        n = 0;
        @(negedge clk_in);
        while ((want_irq ? irq !== 1'b1 : active !== 1'b0) && n < 2000) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 2000) begin
            error_cnt++;
            $display("[FAIL] wait expected done seen %b %b", active, irq);
            finish_test();
        end
    endtask

    initial begin
        arst_n_in = 1'b0;
        address = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h00000000;
        special = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk_in);
        arst_n_in <= 1'b1;
        // reset values and refusals in normal mode
        rchk("status_hi", 8'h66, 8'hff, 8'h00);
        rchk("done_flags", 8'h67, 8'hff, 8'h00);
        wreg(8'h68, 8'h5a);
        rchk("approx_hi", 8'h68, 8'hff, 8'h00);
        rchk("approx_lo", 8'h69, 8'hff, 8'h00);
        rchk("unmapped", 8'h50, 8'hff, 8'h00);
        wreg(8'h62, 8'h80);
        // single channel over input, reference and test codes, normal flag clearing
        for (int i = 0; i < 5; i++) begin
            c = codes[i];
            wreg(8'h65, {4'h0, c});
            @(negedge clk_in);
            chk("channel", {4'h0, c}, {4'h0, channel});
            rchk("done_clr", 8'h66, 8'h87, 8'h00);
            rchk("seq_ctrl", 8'h65, 8'hff, {4'h0, c});
            wait_for(1'b0);
            rchk("result_0", 8'h70, 8'hff, {c, 4'h5});
            rchk("flags_kept", 8'h67, 8'hff, 8'h0f);
            rchk("seq_done", 8'h66, 8'h80, 8'h80);
            for (int n = 0; n < 4; n++) begin
                rchk("result_n", 8'h70 + 8'(n), 8'hff, {c, 4'h5});
            end
            rchk("flags_clr", 8'h67, 8'hff, 8'h00);
        end
        // group of eight, low select bits set but ignored
        wreg(8'h65, 8'h53);
        wait_for(1'b0);
        rchk("flags_8", 8'h67, 8'hff, 8'hff);
        for (int n = 0; n < 8; n++) begin
            rchk("group8", 8'h70 + 8'(n), 8'hff, {4'(n), 4'h5});
        end
        // group of four from the upper block
        wreg(8'h65, 8'h16);
        wait_for(1'b0);
        rchk("flags_4", 8'h67, 8'hff, 8'h0f);
        for (int n = 0; n < 4; n++) begin
            rchk("group4", 8'h70 + 8'(n), 8'hff, {4'(n + 4), 4'h5});
        end
        // repeat run with interrupt, then abort by a new control write
        wreg(8'h62, 8'h82);
        wreg(8'h65, 8'h23);
        wait_for(1'b1);
        @(negedge clk_in);
        chk("still_running", 8'h01, {7'h00, active});
        rchk("seq_done_rep", 8'h66, 8'h80, 8'h80);
        rchk("irq_flag", 8'h62, 8'h01, 8'h01);
        wreg(8'h65, 8'h03);
        rchk("abort_done", 8'h66, 8'h87, 8'h00);
        rchk("abort_flags", 8'h67, 8'hff, 8'h00);
        wait_for(1'b0);
        // fast clearing: result access alone clears flags
        wreg(8'h62, 8'hc0);
        wreg(8'h65, 8'h01);
        wait_for(1'b0);
        rchk("fast_res", 8'h70, 8'hff, 8'h15);
        rchk("fast_flags", 8'h67, 8'hff, 8'h0e);
        rchk("fast_done", 8'h66, 8'h80, 8'h00);
        wreg(8'h71, 8'h00);
        rchk("fast_write", 8'h67, 8'hff, 8'h0c);
        // power bit low stops a running sequence
        wreg(8'h65, 8'h01);
        wreg(8'h62, 8'h00);
        @(posedge clk_in);
        @(negedge clk_in);
        chk("power_abort", 8'h00, {7'h00, active});
        // special mode: test registers, flag writes, module reset
        @(posedge clk_in);
        special <= 1'b1;
        wreg(8'h68, 8'ha5);
        wreg(8'h69, 8'h5a);
        rchk("sar_hi", 8'h68, 8'hff, 8'ha5);
        rchk("sar_lo", 8'h69, 8'hff, 8'h5a);
        @(negedge clk_in);
        chk("test_sel", 8'h0a, {4'h0, test_sel});
        chk("test_mux", 8'h01, {7'h00, test_mux});
        wreg(8'h67, 8'h3c);
        rchk("flag_write", 8'h67, 8'hff, 8'h3c);
        wreg(8'h62, 8'hc2);
        wreg(8'h69, 8'h20);
        rchk("rst_mode", 8'h62, 8'hff, 8'h80);
        rchk("rst_flags", 8'h67, 8'hff, 8'h00);
        rchk("rst_sar", 8'h68, 8'hff, 8'h00);
        special <= 1'b0;
        wreg(8'h67, 8'hff);
        rchk("flag_ro", 8'h67, 8'hff, 8'h00);
        finish_test();
    end
endmodule
